// [shared/lhm_pkg.sv]
// Shared constants and types for the limp-home mode and channel control block.
// Assumes one 100 MHz clock; the serial frame decoder lives outside this block.
package lhm_pkg;

    localparam int unsigned NUM_CH    = 8;
    localparam int unsigned NUM_IN    = 4;
    localparam int unsigned SEL_W     = 2;
    localparam int unsigned SYNC_LEN  = 3;

    localparam logic [NUM_CH-1:0]           ON_RST    = 8'h00;
    localparam logic [NUM_CH-1:0]           INMODE_RST = 8'h00;
    localparam logic [NUM_CH-1:0][SEL_W-1:0] SEL_RST  = 16'h0000;
    localparam logic [NUM_CH-1:0]           OUT_OFF   = 8'h00;
    localparam logic [NUM_CH-NUM_IN-1:0]    UPPER_OFF = 4'h0;

    // Pin levels assumed while the synchronisers fill after reset
    localparam logic RSTPIN_RST = 1'b0;
    localparam logic LIMP_RST   = 1'b0;
    localparam logic IN_RST     = 1'b0;
    // Stand-by is the state left behind by power-on reset
    localparam logic QUIET_RST  = 1'b1;

    // Gray path: standby -> idle -> active, standby/active -> limp
    typedef enum logic [1:0] {
        LHM_STANDBY = 2'b00,
        LHM_IDLE    = 2'b01,
        LHM_ACTIVE  = 2'b11,
        LHM_LIMP    = 2'b10
    } lhm_mode_t;

    // One decoded serial write of the channel control settings
    typedef struct packed {
        logic                           valid;
        logic [NUM_CH-1:0]              on;
        logic [NUM_CH-1:0]              in_mode;
        logic [NUM_CH-1:0][SEL_W-1:0]   sel;
    } lhm_cmd_t;

endpackage

// [rtl/lhm_sync.sv]
// Three-stage pin synchroniser with a two-stage agreement filter.
// Assumes the input is asynchronous to clk; the first stage feeds only the second.
`timescale 1ns/1ps
module lhm_sync #(
    parameter logic RST_VAL = 1'b0
) (
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst,
    // Pin and clean level
    input  wire logic pin,
    output logic      level
);
    logic s1_q;
    logic s2_q;
    logic s3_q;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s1_q <= RST_VAL;
            s2_q <= RST_VAL;
            s3_q <= RST_VAL;
        end else begin
            s1_q <= pin;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    // A change counts only once stages two and three agree
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            level <= RST_VAL;
        end else if (s2_q == s3_q) begin
            level <= s3_q;
        end
    end
endmodule // lhm_sync

// [rtl/lhm_ctrl.sv]
// Mode and channel control of an eight-channel low-side switch.
// Assumes serial frames are decoded elsewhere on clk into lhm_cmd_t and a done pulse.
// Operation
// RULE1: After power-up reset all control settings to defaults and enter stand-by.
// RULE2: Reset pin low forces defaults and the minimum-quiescent stand-by state.
// RULE3: Failsafe input high enters limp-home and clears the control settings.
// RULE4: In limp-home, input pins one to four drive channels one to four.
// RULE5: Channels five to eight stay off throughout limp-home.
// RULE6: Serial writes are ignored during limp-home.
// RULE7: Failsafe input high overrides a low reset pin.
// RULE8: Failsafe high during stand-by wakes the device into limp-home.
// RULE9: Leaving limp-home resets settings, then stand-by if reset low, else idle.
// RULE10: First serial transfer after limp-home reports the transmission error flag.
// RULE11: A per-channel select setting picks which input pin controls that channel.
// RULE12: In input mode selected pin high means on, low means off.
// RULE13: After power-on reset all channels are off in idle until commanded.
// RULE14: Outside input mode each channel follows its serially written on bit.
// RULE15: Reset, failsafe and channel input pins are synchronised before use.
`timescale 1ns/1ps
module lhm_ctrl (
    // Clock and power-on reset
    input  wire logic                    clk,
    input  wire logic                    rst,
    // Device pins
    input  wire logic                    reset_pin_n,
    input  wire logic                    failsafe_drive_input,
    input  wire logic [lhm_pkg::NUM_IN-1:0] channel_input_pin,
    // Decoded serial interface
    input  wire lhm_pkg::lhm_cmd_t       cmd,
    input  wire logic                    transfer_done,
    // Channel drive and status
    output logic [lhm_pkg::NUM_CH-1:0]   power_channel,
    output lhm_pkg::lhm_mode_t           mode,
    output logic                         quiescent,
    output logic                         transmission_error_flag
);
    import lhm_pkg::*;

    logic                           rstpin_s;
    logic                           limp_s;
    logic [NUM_IN-1:0]              in_s;
    lhm_mode_t                      mode_q;
    lhm_mode_t                      mode_d;
    logic [NUM_CH-1:0]              on_q;
    logic [NUM_CH-1:0]              in_mode_q;
    logic [NUM_CH-1:0][SEL_W-1:0]   sel_q;
    logic [NUM_CH-1:0]              drive_d;
    logic                           ter_pending_q;
    logic                           limp_exit;
    logic                           cfg_clear;
    logic                           cfg_write;
    logic                           cfg_any_set;
    logic                           transfer_counted;
    logic [NUM_CH-1:0]              pin_pick;

    // Pin synchronisers
    // Three stages plus the agreement filter cost four cycles of pin latency;
    // a pin pulse shorter than two cycles is filtered out and never acts
    lhm_sync #(.RST_VAL(RSTPIN_RST)) u_sync_rst (
        .clk   (clk),
        .rst   (rst),
        .pin   (reset_pin_n),
        .level (rstpin_s)
    ); // RULE15
    lhm_sync #(.RST_VAL(LIMP_RST)) u_sync_limp (
        .clk   (clk),
        .rst   (rst),
        .pin   (failsafe_drive_input),
        .level (limp_s)
    ); // RULE15
    for (genvar i = 0; i < NUM_IN; i++) begin : g_in_sync
        lhm_sync #(.RST_VAL(IN_RST)) u_sync_in (
            .clk   (clk),
            .rst   (rst),
            .pin   (channel_input_pin[i]),
            .level (in_s[i])
        ); // RULE15
    end

    // The exit cycle still sees mode_q as limp, so writes are refused there as well
    assign limp_exit = (mode_q == LHM_LIMP) && !limp_s;
    // Settings are held at defaults in stand-by, throughout limp-home and on its exit
    assign cfg_clear = (mode_d == LHM_STANDBY) || (mode_d == LHM_LIMP) || limp_exit;
    assign cfg_write = cmd.valid && (mode_q == LHM_IDLE || mode_q == LHM_ACTIVE); // RULE6
    // Any set on or input-mode bit keeps the device out of idle
    assign cfg_any_set = (cmd.on != ON_RST) || (cmd.in_mode != INMODE_RST);
    // Transfers seen in limp-home do not consume the pending error report
    assign transfer_counted = transfer_done && (mode_q != LHM_LIMP); // RULE6

    // Each channel picks its input pin through its own select field
    for (genvar ch = 0; ch < NUM_CH; ch++) begin : g_route
        assign pin_pick[ch] = in_s[sel_q[ch]]; // RULE11
    end

    // Mode selection; failsafe is checked first so it beats the reset pin
    // A failed host may hold the reset pin low, so limp-home must still act
    always_comb begin
        mode_d = mode_q;
        if (limp_s) begin
            mode_d = LHM_LIMP; // RULE3 RULE7 RULE8
        end else if (limp_exit) begin
            mode_d = rstpin_s ? LHM_IDLE : LHM_STANDBY; // RULE9
        end else if (!rstpin_s) begin
            mode_d = LHM_STANDBY; // RULE2
        end else begin
            unique case (mode_q)
                LHM_STANDBY: mode_d = LHM_IDLE; // RULE13
                LHM_IDLE: begin
                    if (cfg_write && cfg_any_set) begin
                        mode_d = LHM_ACTIVE;
                    end
                end
                LHM_ACTIVE: begin
                    if (cfg_write && !cfg_any_set) begin
                        mode_d = LHM_IDLE;
                    end
                end
                LHM_LIMP: mode_d = LHM_LIMP;
            endcase
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            mode_q <= LHM_STANDBY; // RULE1
        end else begin
            mode_q <= mode_d;
        end
    end

    // Control settings written over the serial interface
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            on_q      <= ON_RST; // RULE1
            in_mode_q <= INMODE_RST;
        end else if (cfg_clear) begin
            on_q      <= ON_RST; // RULE2 RULE3 RULE9
            in_mode_q <= INMODE_RST;
        end else if (cfg_write) begin
            on_q      <= cmd.on;
            in_mode_q <= cmd.in_mode;
        end
    end

    // Input-select fields, cleared together with the on and mode bits
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sel_q <= SEL_RST; // RULE1
        end else if (cfg_clear) begin
            sel_q <= SEL_RST; // RULE3 RULE9
        end else if (cfg_write) begin
            sel_q <= cmd.sel; // RULE11
        end
    end

    // Channel drive; the next mode is used so outputs change with the mode register
    always_comb begin
        drive_d = OUT_OFF;
        unique case (mode_d)
            LHM_STANDBY: drive_d = OUT_OFF;
            LHM_LIMP:    drive_d = {UPPER_OFF, in_s}; // RULE4 RULE5
            LHM_IDLE,
            LHM_ACTIVE: begin
                // The exit cycle drives all off before the cleared settings take hold
                if (!limp_exit) begin
                    for (int c = 0; c < NUM_CH; c++) begin
                        if (in_mode_q[c]) begin
                            drive_d[c] = pin_pick[c]; // RULE11 RULE12
                        end else begin
                            drive_d[c] = on_q[c]; // RULE14
                        end
                    end
                end
            end
        endcase
    end

    // Registered so the channels never glitch while the mode decode settles
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            power_channel <= OUT_OFF; // RULE13
        end else begin
            power_channel <= drive_d;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            mode <= LHM_STANDBY; // RULE1
        end else begin
            mode <= mode_d;
        end
    end

    // Quiescent flag tracks the stand-by state the mode register is entering
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            quiescent <= QUIET_RST;
        end else begin
            quiescent <= (mode_d == LHM_STANDBY); // RULE2
        end
    end

    // Error report; a limp exit in the same cycle as a transfer stays pending
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ter_pending_q <= 1'b0;
        end else if (limp_exit) begin
            ter_pending_q <= 1'b1; // RULE10
        end else if (transfer_counted) begin
            ter_pending_q <= 1'b0;
        end
    end

    // Level stands until the next counted transfer
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            transmission_error_flag <= 1'b0;
        end else if (transfer_counted) begin
            transmission_error_flag <= ter_pending_q || limp_exit; // RULE10
        end
    end
endmodule // lhm_ctrl

// [test/lhm_ctrl_props.sv]
// Port checker for lhm_ctrl.
// Assumes one clock and async reset rst.
`timescale 1ns/1ps
module lhm_ctrl_props (
    // Clock and reset
    input wire logic                       clk,
    input wire logic                       rst,
    // Pins and serial side
    input wire logic                       reset_pin_n,
    input wire logic                       failsafe_drive_input,
    input wire logic [lhm_pkg::NUM_IN-1:0] channel_input_pin,
    input wire lhm_pkg::lhm_cmd_t          cmd,
    input wire logic                       transfer_done,
    // Outputs
    input wire logic [lhm_pkg::NUM_CH-1:0] power_channel,
    input wire lhm_pkg::lhm_mode_t         mode,
    input wire logic                       quiescent,
    input wire logic                       transmission_error_flag
);
    import lhm_pkg::*;
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    upper_off_a: assert property (mode == LHM_LIMP |-> power_channel[7:4] == 4'h0)
        else $error("upper on in limp");
    // Pins must be steady long enough to pass the synchronisers
    limp_route_a: assert property ((mode == LHM_LIMP && $stable(channel_input_pin)) [*8]
        |-> power_channel[3:0] == channel_input_pin) else $error("limp routing");
    standby_off_a: assert property (mode == LHM_STANDBY |-> power_channel == OUT_OFF && quiescent)
        else $error("standby not off");
    quiet_mode_a: assert property (quiescent |-> mode == LHM_STANDBY)
        else $error("quiescent outside standby");
    limp_deaf_a: assert property (cmd.valid && mode == LHM_LIMP |=> mode != LHM_ACTIVE
        ##1 (mode == LHM_LIMP || power_channel == OUT_OFF)) else $error("serial taken in limp");
    limp_exit_a: assert property (mode == LHM_LIMP ##1 mode != LHM_LIMP
        |-> mode != LHM_ACTIVE && power_channel == OUT_OFF) else $error("limp exit");
    serial_on_a: assert property (cmd.valid && cmd.in_mode == INMODE_RST && mode[0]
        |-> ##2 (!mode[0] || power_channel == $past(cmd.on, 2))) else $error("on bits");
    flag_hold_a: assert property (transfer_done && mode == LHM_LIMP |=> $stable(transmission_error_flag))
        else $error("flag moved in limp");
    flag_cause_a: assert property ($rose(transmission_error_flag) |-> $past(transfer_done))
        else $error("flag without transfer");
    cover property (mode == LHM_LIMP);
    cover property (mode == LHM_ACTIVE);
    cover property ($rose(transmission_error_flag));
endmodule // lhm_ctrl_props

bind lhm_ctrl lhm_ctrl_props u_props (.clk, .rst, .reset_pin_n, .failsafe_drive_input,
    .channel_input_pin, .cmd, .transfer_done, .power_channel, .mode, .quiescent,
    .transmission_error_flag);

// [test/lhm_host.sv]
// Host model driving the pins and decoded serial writes.
// Assumes tasks are called from one process.
`timescale 1ns/1ps
module lhm_host (
    // Clock
    input  wire logic         clk,
    // Pins and serial side
    output logic              reset_pin_n,
    output logic              failsafe_drive_input,
    output logic [3:0]        channel_input_pin,
    output lhm_pkg::lhm_cmd_t cmd,
    output logic              transfer_done
);
    import lhm_pkg::*;
    initial begin
        reset_pin_n = 1'b0;
        failsafe_drive_input = 1'b0;
        channel_input_pin = 4'h0;
        cmd = '0;
        transfer_done = 1'b0;
    end
    // Eight edges cover synchroniser and output latency
    task automatic pins(input logic r, input logic f, input logic [3:0] p);
        @(posedge clk);
        reset_pin_n <= r;
        failsafe_drive_input <= f;
        channel_input_pin <= p;
        repeat (8) @(posedge clk);
        #1;
    endtask
    task automatic send(input logic [7:0] on, input logic [7:0] im, input logic [15:0] sel);
        @(posedge clk);
        cmd <= '{1'b1, on, im, sel};
        transfer_done <= 1'b1;
        @(posedge clk);
        cmd.valid <= 1'b0;
        transfer_done <= 1'b0;
        repeat (3) @(posedge clk);
        #1;
    endtask
endmodule // lhm_host

// [test/lhm_ctrl_tb.sv]
// Self-checking bench for lhm_ctrl.
// Assumes host tasks return settled.
`timescale 1ns/1ps
module lhm_ctrl_tb;
    import lhm_pkg::*;
    logic      clk = 1'b0;
    logic      rst = 1'b1;
    logic      r_n, fs, td, qs, fl;
    logic [3:0] pin;
    logic [7:0] pc;
    lhm_cmd_t  cmd;
    lhm_mode_t md;
    int        n_fail = 0;
    int        check_count = 0;
    always #5 clk = ~clk;
    lhm_host u_host (.clk, .reset_pin_n(r_n), .failsafe_drive_input(fs),
        .channel_input_pin(pin), .cmd, .transfer_done(td));
    lhm_ctrl dut (.clk, .rst, .reset_pin_n(r_n), .failsafe_drive_input(fs),
        .channel_input_pin(pin), .cmd, .transfer_done(td), .power_channel(pc),
        .mode(md), .quiescent(qs), .transmission_error_flag(fl));
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chk_mode(input lhm_mode_t got, input lhm_mode_t exp);
        chk({6'h00, got}, {6'h00, exp});
    endtask
    task automatic t_reset;
        #1;
        chk_mode(md, LHM_STANDBY);
        chk({7'h00, qs}, 8'h01);
        u_host.pins(1'b1, 1'b0, 4'h0);
        chk_mode(md, LHM_IDLE);
        chk(pc, OUT_OFF);
        chk({7'h00, qs}, 8'h00);
        $display("t_reset done");
    endtask
    task automatic t_serial;
        u_host.send(8'hA5, 8'h00, 16'h0000);
        chk(pc, 8'hA5);
        u_host.pins(1'b1, 1'b0, 4'h3);
        u_host.send(8'h05, 8'hF0, 16'h1BE4);
        chk(pc, 8'hC5);
        u_host.pins(1'b1, 1'b0, 4'hC);
        chk(pc, 8'h35);
        u_host.pins(1'b0, 1'b0, 4'hC);
        chk_mode(md, LHM_STANDBY);
        chk(pc, OUT_OFF);
        chk({7'h00, qs}, 8'h01);
        u_host.send(8'hFF, 8'h00, 16'h0000);
        u_host.pins(1'b1, 1'b0, 4'hC);
        chk_mode(md, LHM_IDLE);
        chk(pc, OUT_OFF);
        $display("t_serial done");
    endtask
    task automatic t_limp;
        u_host.send(8'h0F, 8'h00, 16'h0000);
        chk(pc, 8'h0F);
        u_host.pins(1'b1, 1'b1, 4'hB);
        chk_mode(md, LHM_LIMP);
        chk(pc, 8'h0B);
        u_host.send(8'hFF, 8'h00, 16'h0000);
        chk(pc, 8'h0B);
        u_host.pins(1'b1, 1'b0, 4'hB);
        chk_mode(md, LHM_IDLE);
        chk(pc, OUT_OFF);
        u_host.pins(1'b0, 1'b1, 4'hB);
        chk_mode(md, LHM_LIMP);
        u_host.pins(1'b0, 1'b0, 4'hB);
        chk_mode(md, LHM_STANDBY);
        chk(pc, OUT_OFF);
        u_host.pins(1'b0, 1'b1, 4'h5);
        chk(pc, 8'h05);
        u_host.pins(1'b1, 1'b0, 4'h5);
        chk_mode(md, LHM_IDLE);
        chk(pc, OUT_OFF);
        u_host.send(8'h00, 8'h00, 16'h0000);
        chk({7'h00, fl}, 8'h01);
        u_host.send(8'h00, 8'h00, 16'h0000);
        chk({7'h00, fl}, 8'h00);
        $display("t_limp done");
    endtask
    task automatic summarize;
        $display("checks=%0d mismatches=%0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    initial begin
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_serial();
        t_limp();
        summarize();
    end
    initial begin
        #20000;
        n_fail++;
        summarize();
    end
endmodule // lhm_ctrl_tb
